/* hdl/pphp_top.sv */
// Purpose: host port of the pixel processor: sequencer and area (c) registers
// Assumes: host keeps selects, address, WE and BE stable until grant drops
// Notes:   areas a, b and pointer RAM are served outside over the area bus
`timescale 1ns/100ps
`default_nettype none
module pphp_top
   import pphp_pkg::*;
#(
   parameter int HOLD = REQ_HOLD_CYCLES
) (
   input  wire logic                SYS_CLK,
   input  wire logic                SYS_RST,
   input  wire logic                HOST_REQUEST_N,
   input  wire logic                REGISTER_SELECT_N,
   input  wire logic                MEMORY_SELECT_N,
   input  wire logic                ADDR_LATCH_ENABLE_N,
   input  wire logic [8:2]          ADDR_IN,
   input  wire logic                WRITE_ENABLE_N_IN,
   input  wire logic [3:0]          BYTE_ENABLES_N_IN,
   input  wire logic [DATA_W-1:0]   DATA_IN,
   output var  logic [DATA_W-1:0]   DATA_OUT,
   output var  logic                DATA_OE,
   output var  logic                BUS_OE,
   output var  logic                HOST_BUS_GRANT_N,
   output var  logic                HOST_READY_N,
   output var  logic                HOST_IRQ_N,
   output var  logic                MEMORY_REQUEST_N,
   input  wire logic                MEMORY_READY_N,
   input  wire logic                HALT_PIN_N,
   input  wire pphp_irq_type        IRQ_EVENTS,
   input  wire logic                FROZEN_INDICATOR,
   input  wire logic                PROFILE_TOGGLE,
   output var  logic                MONITOR_PIN_N,
   output var  logic                PROC_HALT,
   output var  logic                SINGLE_STEP,
   output var  logic                NATIVE_MODE,
   output var  pphp_area_type       AREA_ACCESS,
   input  wire logic [WORD_W-1:0]   AREA_RDATA
);

   localparam int SYNC_W = 11 + 7 + DATA_W;
   localparam logic [SYNC_W-1:0] SYNC_RST = {11'h7FF, 7'h00, 32'h00000000};

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisation

   logic [SYNC_W-1:0] sync_q;
   logic              req;
   logic              reg_sel_n;
   logic              mem_sel_n;
   logic              ale;
   logic              we_n;
   logic [3:0]        be_n;
   logic              mem_ready;
   logic              halt_pin;
   logic [8:2]        addr;
   logic [DATA_W-1:0] wdata;

   pphp_sync #(
      .WIDTH (SYNC_W)
   ) u_sync (
      .clk       (SYS_CLK),
      .rst       (SYS_RST),
      .rst_value (SYNC_RST),
      .async_in  ({HOST_REQUEST_N, REGISTER_SELECT_N, MEMORY_SELECT_N,
                   ADDR_LATCH_ENABLE_N, WRITE_ENABLE_N_IN, BYTE_ENABLES_N_IN,
                   MEMORY_READY_N, HALT_PIN_N, ADDR_IN, DATA_IN}),
      .sync_out  (sync_q)
   );

   assign req       = ~sync_q[SYNC_W-1];
   assign reg_sel_n = sync_q[SYNC_W-2];
   assign mem_sel_n = sync_q[SYNC_W-3];
   assign ale       = ~sync_q[SYNC_W-4];
   assign we_n      = sync_q[SYNC_W-5];
   assign be_n      = sync_q[SYNC_W-6 -: 4];
   assign mem_ready = ~sync_q[SYNC_W-10];
   assign halt_pin  = ~sync_q[SYNC_W-11];
   assign addr      = sync_q[DATA_W +: 7];
   assign wdata     = sync_q[DATA_W-1:0];

   ////////////////////////////////////////////////////////////////////////
   // Decode helpers

   function automatic pphp_cycle_type cycle_of(input logic r_n, input logic m_n);
      case ({r_n, m_n})
         2'b11:   cycle_of = CYC_EXTERNAL;
         2'b01:   cycle_of = CYC_REGISTER;
         2'b10:   cycle_of = CYC_VRAM;
         default: cycle_of = CYC_RESERVED;
      endcase
   endfunction

   // Word select folds into offset bit 1; bit 0 always zero
   function automatic logic [OFF_W:0] offset_of(input logic [8:2] a, input logic [3:0] b);
      offset_of = {(b == BE_LO_WORD) || (b == BE_HI_WORD), a, b == BE_HI_WORD, 1'b0};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Sequencer

   pphp_state_type    state;
   pphp_state_type    next_state;
   pphp_cycle_type    cycle;
   pphp_cycle_type    next_cycle;
   logic [1:0]        hold_cnt;
   logic [1:0]        next_hold_cnt;
   logic              is_write;
   logic              next_is_write;
   logic              off_valid;
   logic              next_off_valid;
   logic [OFF_W-1:0]  offset;
   logic [OFF_W-1:0]  next_offset;
   logic              reg_cyc;

   assign reg_cyc = (cycle == CYC_REGISTER) || (cycle == CYC_RESERVED);

   always_comb begin
      next_state     = state;
      next_cycle     = cycle;
      next_hold_cnt  = hold_cnt;
      next_is_write  = is_write;
      next_off_valid = off_valid;
      next_offset    = offset;
      case (state)
         st_idle: begin
            if (!req) begin
               next_hold_cnt = 2'h0;
            end else if (hold_cnt == 2'(HOLD - 1)) begin
               next_hold_cnt = 2'h0;
               next_state    = st_release;
            end else begin
               next_hold_cnt = hold_cnt + 2'h1;
            end
         end
         st_release: begin
            next_cycle = cycle_of(reg_sel_n, mem_sel_n);
            if (next_cycle == CYC_EXTERNAL) begin
               next_state = st_turnaround;
            end else begin
               next_state = st_granted;
            end
         end
         st_granted: begin
            if (ale) begin
               {next_off_valid, next_offset} = offset_of(addr, be_n);
               next_is_write = ~we_n;
               if (cycle == CYC_VRAM) begin
                  next_state = st_mem_issue;
               end else begin
                  next_state = st_turnaround;
               end
            end
         end
         st_mem_issue: begin
            next_state = st_mem_wait;
         end
         st_mem_wait: begin
            if (mem_ready) begin
               next_state = st_turnaround;
            end
         end
         st_turnaround: begin
            next_state = st_complete_wait;
         end
         st_complete_wait: begin
            if (!req) begin
               next_state = st_terminate;
            end
         end
         st_terminate: begin
            next_state = st_idle;
         end
         default: begin
            next_state = st_idle;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         state     <= st_idle;
         cycle     <= CYC_EXTERNAL;
         hold_cnt  <= 2'h0;
         is_write  <= 1'b0;
         off_valid <= 1'b0;
         offset    <= '0;
      end else begin
         state     <= next_state;
         cycle     <= next_cycle;
         hold_cnt  <= next_hold_cnt;
         is_write  <= next_is_write;
         off_valid <= next_off_valid;
         offset    <= next_offset;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register file and area access

   pphp_ctrl_type     ctrl;
   pphp_ctrl_type     next_ctrl;
   pphp_irq_type      flags;
   pphp_irq_type      next_flags;
   logic              mc_overflow;
   logic              next_mc_overflow;
   logic [WORD_W-1:0] rdata;
   logic [WORD_W-1:0] next_rdata;
   logic              step;
   logic              next_step;
   pphp_area_type     area;
   pphp_area_type     next_area;
   logic              rd_cycle;
   logic              rd_issue;
   logic              wr_done;
   logic              reg_ok;
   logic              in_ctrl;
   logic              flag_clear;
   logic [WORD_W-1:0] flag_word;
   logic [WORD_W-1:0] stat_word;

   // Reserved cycle type treated as register cycle
   assign reg_ok   = reg_cyc && off_valid;
   assign in_ctrl  = offset[OFF_W-1 -: 2] == AREA_CTRL;
   assign rd_cycle = (state == st_turnaround) && reg_ok && !is_write;
   assign wr_done  = (state == st_complete_wait) && !req && reg_ok && is_write;
   assign flag_clear = rd_cycle && in_ctrl && (offset == CTRL_OFF);
   // Read strobe leads the capture so area data answers this offset
   assign rd_issue = (state == st_granted) && (next_state == st_turnaround) && reg_cyc
                     && next_off_valid && !next_is_write && (next_offset[OFF_W-1 -: 2] != AREA_CTRL);

   always_comb begin
      flag_word = '0;
      flag_word[FLAG_EF_BIT]  = flags.even_field;
      flag_word[FLAG_OF_BIT]  = flags.odd_field;
      flag_word[FLAG_OVF_BIT] = mc_overflow;
      flag_word[FLAG_SD_BIT]  = flags.shutdown;
      flag_word[FLAG_MC_BIT]  = flags.microcode;
      flag_word[FLAG_VB_BIT]  = flags.vblank;
      flag_word[FLAG_DFL_BIT] = flags.format_load;
      stat_word = '0;
      stat_word[STAT_HALT_BIT] = ctrl.halt || halt_pin;
      stat_word[STAT_FRZ_BIT]  = FROZEN_INDICATOR;
      stat_word[STAT_PROF_BIT] = PROFILE_TOGGLE;
      stat_word[STAT_MASK_LSB +: 6] = ctrl.enables;
   end

   always_comb begin
      next_ctrl        = ctrl;
      next_step        = 1'b0;
      next_rdata       = rdata;
      next_area        = area;
      next_area.strobe = 1'b0;
      // Set wins over the read clear
      next_flags       = (flag_clear ? '0 : flags) | IRQ_EVENTS;
      next_mc_overflow = (mc_overflow && !flag_clear)
                         || (IRQ_EVENTS.microcode && flags.microcode && !flag_clear);
      if (rd_cycle) begin
         if (!in_ctrl) begin
            next_rdata = AREA_RDATA;
         end else if (offset == CTRL_OFF) begin
            next_rdata = flag_word;
         end else if (offset == STAT_OFF) begin
            next_rdata = stat_word;
         end else begin
            next_rdata = '0;
         end
      end else if (state == st_granted) begin
         next_rdata = '0;
      end
      // Area strobe is the one-cycle transfer that halts the processor
      if (rd_issue || (wr_done && !in_ctrl)) begin
         next_area.strobe = 1'b1;
         next_area.write  = !rd_issue;
         next_area.offset = rd_issue ? next_offset : offset;
         next_area.wdata  = wdata[WORD_W-1:0];
      end
      if (wr_done && in_ctrl && (offset == CTRL_OFF)) begin
         next_ctrl.halt        = wdata[CTRL_HALT_BIT];
         next_step             = wdata[CTRL_STEP_BIT] && ctrl.halt && wdata[CTRL_HALT_BIT];
         next_ctrl.enables     = wdata[CTRL_EN_LSB +: 6];
         next_ctrl.monitor_sel = wdata[CTRL_MON_BIT];
         next_ctrl.native      = wdata[CTRL_NATIVE_BIT];
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         ctrl        <= '{native: 1'b0, monitor_sel: 1'b0, enables: '0, halt: 1'b1};
         flags       <= '0;
         mc_overflow <= 1'b0;
         rdata       <= '0;
         step        <= 1'b0;
         area        <= '0;
      end else begin
         ctrl        <= next_ctrl;
         flags       <= next_flags;
         mc_overflow <= next_mc_overflow;
         rdata       <= next_rdata;
         step        <= next_step;
         area        <= next_area;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin outputs

   logic granted;

   assign granted = (state == st_granted) || (state == st_turnaround) || (state == st_complete_wait)
                    || (state == st_mem_issue) || (state == st_mem_wait);

   always_comb begin
      // Device owns the bus only outside host transactions
      BUS_OE           = (state == st_idle);
      HOST_BUS_GRANT_N = ~granted;
      MEMORY_REQUEST_N = ~(state == st_mem_issue);
      // Memory drives data on VRAM reads; host on writes
      DATA_OE          = reg_cyc && !is_write
                         && ((state == st_turnaround) || (state == st_complete_wait));
      if (cycle == CYC_EXTERNAL) begin
         HOST_READY_N = ~(mem_ready
                          && ((state == st_turnaround) || (state == st_complete_wait)));
      end else begin
         HOST_READY_N = ~(state == st_complete_wait);
      end
      HOST_IRQ_N    = ~|(flags & ctrl.enables);
      MONITOR_PIN_N = ctrl.monitor_sel ? ~PROFILE_TOGGLE : ~FROZEN_INDICATOR;
      PROC_HALT     = ctrl.halt || area.strobe;
      SINGLE_STEP   = step;
      NATIVE_MODE   = ctrl.native;
      AREA_ACCESS   = area;
      DATA_OUT      = {rdata, rdata};
   end

endmodule
`default_nettype wire

/* hdl/pphp_pkg.sv */
// Purpose: shared constants and types of the pixel processor host port
// Assumes: byte offsets are 9 bits wide (areas 0x000 to 0x1FE)
// Notes:   bit positions and offsets are named here only
package pphp_pkg;

   localparam int          REQ_HOLD_CYCLES = 2;
   localparam int          DATA_W          = 32;
   localparam int          WORD_W          = 16;
   localparam int          OFF_W           = 9;

   localparam logic [OFF_W-1:0] CTRL_OFF   = 9'h100;
   localparam logic [OFF_W-1:0] STAT_OFF   = 9'h102;

   localparam logic [1:0]  AREA_A          = 2'h0;
   localparam logic [1:0]  AREA_B          = 2'h1;
   localparam logic [1:0]  AREA_CTRL       = 2'h2;
   localparam logic [1:0]  AREA_PTR        = 2'h3;

   localparam logic [3:0]  BE_LO_WORD      = 4'hC;
   localparam logic [3:0]  BE_HI_WORD      = 4'h3;

   localparam int          CTRL_HALT_BIT   = 0;
   localparam int          CTRL_STEP_BIT   = 1;
   localparam int          CTRL_EN_LSB     = 2;
   localparam int          CTRL_MON_BIT    = 13;
   localparam int          CTRL_NATIVE_BIT = 15;

   localparam int          FLAG_EF_BIT     = 9;
   localparam int          FLAG_OF_BIT     = 10;
   localparam int          FLAG_OVF_BIT    = 11;
   localparam int          FLAG_SD_BIT     = 12;
   localparam int          FLAG_MC_BIT     = 13;
   localparam int          FLAG_VB_BIT     = 14;
   localparam int          FLAG_DFL_BIT    = 15;

   localparam int          STAT_HALT_BIT   = 0;
   localparam int          STAT_FRZ_BIT    = 1;
   localparam int          STAT_PROF_BIT   = 2;
   localparam int          STAT_MASK_LSB   = 10;

   // Order matches control bits 7:2 and status bits 15:10
   typedef struct packed {
      logic even_field;
      logic odd_field;
      logic shutdown;
      logic format_load;
      logic vblank;
      logic microcode;
   } pphp_irq_type;

   typedef struct packed {
      logic         native;
      logic         monitor_sel;
      pphp_irq_type enables;
      logic         halt;
   } pphp_ctrl_type;

   typedef struct packed {
      logic             strobe;
      logic             write;
      logic [OFF_W-1:0] offset;
      logic [WORD_W-1:0] wdata;
   } pphp_area_type;

   typedef enum logic [1:0] {
      CYC_EXTERNAL = 2'h0,
      CYC_REGISTER = 2'h1,
      CYC_VRAM     = 2'h2,
      CYC_RESERVED = 2'h3
   } pphp_cycle_type;

   typedef enum logic [2:0] {
      st_idle          = 3'h0,
      st_release       = 3'h1,
      st_granted       = 3'h2,
      st_turnaround    = 3'h3,
      st_complete_wait = 3'h4,
      st_terminate     = 3'h5,
      st_mem_issue     = 3'h6,
      st_mem_wait      = 3'h7
   } pphp_state_type;

endpackage

/* hdl/pphp_sync.sv */
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs asynchronous to SYS_CLK
// Notes:   output follows only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pphp_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] rst_value,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] next_out;

   // Stage one feeds stage two only
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         next_out[i] = (stage2[i] == stage3[i]) ? stage3[i] : sync_out[i];
      end
   end

   // Reset value port only reaches a synchronous reset path
   always_ff @(posedge clk) begin
      if (rst) begin
         stage1   <= rst_value;
         stage2   <= rst_value;
         stage3   <= rst_value;
         sync_out <= rst_value;
      end else begin
         stage1   <= async_in;
         stage2   <= stage1;
         stage3   <= stage2;
         sync_out <= next_out;
      end
   end

endmodule
`default_nettype wire

/* bench/pphp_top_sva.sv */
// Purpose: concurrent checks on the host port pins
// Assumes: one clock, synchronous active-high reset
// Notes:   synchroniser lag makes some bounds loose on purpose
`timescale 1ns/100ps
`default_nettype none
module pphp_top_sva
   import pphp_pkg::*;
(
   input wire logic          SYS_CLK,
   input wire logic          SYS_RST,
   input wire logic          HOST_REQUEST_N,
   input wire logic          REGISTER_SELECT_N,
   input wire logic          MEMORY_SELECT_N,
   input wire logic          MEMORY_READY_N,
   input wire logic          MEMORY_REQUEST_N,
   input wire logic          HOST_BUS_GRANT_N,
   input wire logic          HOST_READY_N,
   input wire logic          HOST_IRQ_N,
   input wire logic          BUS_OE,
   input wire logic          DATA_OE,
   input wire logic          PROC_HALT,
   input wire logic          SINGLE_STEP,
   input wire logic          NATIVE_MODE,
   input wire logic          MONITOR_PIN_N,
   input wire logic          FROZEN_INDICATOR,
   input wire pphp_area_type AREA_ACCESS
);
////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge SYS_CLK);
   endclocking
   default disable iff (SYS_RST);
////////////////////////////////////////////////////////////////////////////////
   memory_request_n_pulse_a:
      assert property ($fell(MEMORY_REQUEST_N) |=> MEMORY_REQUEST_N) else $error("memory request too long");
   vram_no_drive_a:
      assert property (!MEMORY_REQUEST_N |-> !HOST_BUS_GRANT_N && !DATA_OE) else $error("data driven on vram");
   mem_wait_a:
      assert property ($rose(MEMORY_REQUEST_N) ##0 MEMORY_READY_N[*4] |-> HOST_READY_N[*4])
         else $error("left memory wait early");
   memory_request_n_done_a:
      assert property ($fell(MEMORY_REQUEST_N) |-> ##[1:40] !HOST_READY_N) else $error("vram never completed");
   ready_grant_a:
      assert property (!HOST_READY_N |-> !HOST_BUS_GRANT_N) else $error("ready without grant");
   ready_req_a:
      assert property (!HOST_READY_N && !HOST_REQUEST_N |=> !HOST_BUS_GRANT_N) else $error("ended before request");
   grant_dead_a:
      assert property ($fell(HOST_BUS_GRANT_N) |-> !$past(BUS_OE) && !BUS_OE) else $error("no release before grant");
   ext_ready_a:
      assert property ((REGISTER_SELECT_N && MEMORY_SELECT_N && MEMORY_READY_N)[*6] |-> HOST_READY_N)
         else $error("external ready without memory ready");
   reset_vals_a:
      assert property ($fell(SYS_RST) |-> PROC_HALT && !NATIVE_MODE && HOST_IRQ_N
                       && (MONITOR_PIN_N == !FROZEN_INDICATOR)) else $error("wrong reset values");
   strobe_halt_a:
      assert property (AREA_ACCESS.strobe |-> PROC_HALT ##1 !AREA_ACCESS.strobe) else $error("area halt wrong");
   step_pulse_a:
      assert property (SINGLE_STEP |-> PROC_HALT ##1 !SINGLE_STEP) else $error("single step wrong");
////////////////////////////////////////////////////////////////////////////////
   cover property (!MEMORY_REQUEST_N);
   cover property (AREA_ACCESS.strobe && AREA_ACCESS.write);
   cover property (SINGLE_STEP);
endmodule
bind pphp_top pphp_top_sva pphp_top_sva_i (.*);
`default_nettype wire

/* bench/pphp_vram_model.sv */
// Purpose: memory array and external device seen from the port
// Assumes: request is a one-cycle low pulse
// Notes:   ready window is four cycles so the synchroniser sees it
`timescale 1ns/100ps
`default_nettype none
module pphp_vram_model (
   input  wire logic clk,
   input  wire logic mem_req_n,
   input  wire logic ext_ready,
   input  wire logic [31:0] delay,
   output var  logic mem_ready_n
);
   int cnt = 0;
   int next_cnt;
////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_cnt = (cnt > 0) ? cnt - 1 : 0;
      if (mem_req_n === 1'b0) begin
         next_cnt = int'(delay) + 4;
      end
   end
   always_ff @(posedge clk) begin
      cnt <= next_cnt;
   end
   // External logic answers as a level, memory in a bounded window
   always_comb begin
      mem_ready_n = !(ext_ready || (cnt > 0 && cnt <= 4));
   end
endmodule
`default_nettype wire

/* bench/tb.sv */
// Purpose: self-checking bench of the host port
// Assumes: clock 100 MHz, inputs driven on the falling edge
// Notes:   area read data is a fixed function of the offset
`timescale 1ns/100ps
`default_nettype none
module tb
   import pphp_pkg::*;
;
   logic              SYS_CLK, SYS_RST, HOST_REQUEST_N, REGISTER_SELECT_N, MEMORY_SELECT_N;
   logic              ADDR_LATCH_ENABLE_N, WRITE_ENABLE_N_IN, HALT_PIN_N, FROZEN_INDICATOR;
   logic              PROFILE_TOGGLE, MEMORY_READY_N, HOST_BUS_GRANT_N, HOST_READY_N, HOST_IRQ_N;
   logic              MEMORY_REQUEST_N, DATA_OE, BUS_OE, MONITOR_PIN_N, PROC_HALT, SINGLE_STEP;
   logic              NATIVE_MODE, r, ext_ready, last_we;
   logic [8:2]        ADDR_IN;
   logic [3:0]        BYTE_ENABLES_N_IN;
   logic [DATA_W-1:0] DATA_IN, DATA_OUT;
   logic [WORD_W-1:0] AREA_RDATA, rd, last_wd;
   logic [OFF_W-1:0]  last_off;
   pphp_irq_type      IRQ_EVENTS;
   pphp_area_type     AREA_ACCESS;
   int                delay, err_count, compares, steps, mreqs, strobes, cyc;
   int                fb[6] = '{FLAG_MC_BIT, FLAG_VB_BIT, FLAG_DFL_BIT, FLAG_SD_BIT, FLAG_OF_BIT, FLAG_EF_BIT};
   logic [8:0]        ao[3] = '{9'h042, 9'h084, 9'h1A2};
   int                dl[2] = '{1, 9};
////////////////////////////////////////////////////////////////////////////////
   pphp_top pphp_top_i (.*);
   pphp_vram_model pphp_vram_model_i (.clk(SYS_CLK), .mem_req_n(MEMORY_REQUEST_N), .ext_ready(ext_ready),
                                      .delay(delay), .mem_ready_n(MEMORY_READY_N));
   assign AREA_RDATA = {7'h00, AREA_ACCESS.offset} ^ 16'hA5C3;
   initial begin
      SYS_CLK = 1'b0;
      forever #5 SYS_CLK = ~SYS_CLK;
   end
   always @(posedge SYS_CLK) begin
      cyc <= cyc + 1;
      if (SINGLE_STEP === 1'b1) steps <= steps + 1;
      if (MEMORY_REQUEST_N === 1'b0) mreqs <= mreqs + 1;
      if (AREA_ACCESS.strobe === 1'b1) begin
         strobes <= strobes + 1;
         {last_we, last_off, last_wd} <= {AREA_ACCESS.write, AREA_ACCESS.offset, AREA_ACCESS.wdata};
      end
      // Ceiling well above the fewer than two thousand cycles the tests need
      if (cyc == 8000) begin
         err_count = err_count + 1;
         close_out();
      end
   end
////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string s, input logic [15:0] e, g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic chk1(input string s, input logic e, g);
      chk(s, 16'(e), 16'(g));
   endtask
   task automatic host(input logic rs_n, ms_n, we_n, input logic [8:0] off, input logic [15:0] wd,
                       input logic [3:0] be);
      int n;
      @(negedge SYS_CLK);
      {HOST_REQUEST_N, REGISTER_SELECT_N, MEMORY_SELECT_N} = {1'b0, rs_n, ms_n};
      for (n = 0; n < 40 && HOST_BUS_GRANT_N !== 1'b0; n++) @(negedge SYS_CLK);
      chk1("grant", 1'b0, HOST_BUS_GRANT_N);
      chk1("bus released", 1'b0, BUS_OE);
      ADDR_IN = off[8:2];
      WRITE_ENABLE_N_IN = we_n;
      BYTE_ENABLES_N_IN = be;
      DATA_IN = {wd, wd};
      // Address goes through the same synchroniser, so latch enable trails it
      repeat (3) @(negedge SYS_CLK);
      ADDR_LATCH_ENABLE_N = rs_n & ms_n;
      n = 0;
      do begin
         @(posedge SYS_CLK);
         n++;
      end while (HOST_READY_N !== 1'b0 && n < 40);
      r = (HOST_READY_N === 1'b0);
      rd = DATA_OUT[15:0];
      if (!rs_n) chk1("reg ready", 1'b1, r);
      if (!rs_n) chk1("data drive", we_n, DATA_OE);
      if (r && we_n && !rs_n) chk("pair", DATA_OUT[31:16], rd);
      @(negedge SYS_CLK);
      HOST_REQUEST_N = 1'b1;
      for (n = 0; n < 40 && HOST_BUS_GRANT_N !== 1'b1; n++) @(negedge SYS_CLK);
      {ADDR_LATCH_ENABLE_N, REGISTER_SELECT_N, MEMORY_SELECT_N} = 3'h7;
      DATA_IN = ~DATA_IN;
      BYTE_ENABLES_N_IN = ~be;
      repeat (6) @(negedge SYS_CLK);
   endtask
   task automatic wr(input logic [8:0] off, input logic [15:0] v);
      host(1'b0, 1'b1, 1'b0, off, v, off[1] ? BE_HI_WORD : BE_LO_WORD);
   endtask
   task automatic rdc(input logic [8:0] off, input logic [15:0] m, e, input string s);
      host(1'b0, 1'b1, 1'b1, off, 16'h0000, off[1] ? BE_HI_WORD : BE_LO_WORD);
      chk(s, e, rd & m);
   endtask
   task automatic pulse(input logic [5:0] v);
      @(negedge SYS_CLK);
      IRQ_EVENTS = v;
      @(negedge SYS_CLK);
      IRQ_EVENTS = 6'h00;
      @(negedge SYS_CLK);
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
////////////////////////////////////////////////////////////////////////////////
   initial begin
      {HOST_REQUEST_N, REGISTER_SELECT_N, MEMORY_SELECT_N, ADDR_LATCH_ENABLE_N} = 4'hF;
      {WRITE_ENABLE_N_IN, HALT_PIN_N, FROZEN_INDICATOR, PROFILE_TOGGLE, ext_ready} = 5'h18;
      {ADDR_IN, BYTE_ENABLES_N_IN, DATA_IN, IRQ_EVENTS} = 49'h0;
      {err_count, compares, steps, mreqs, strobes, cyc} = '0;
      delay = 2;
      SYS_RST = 1'b1;
      repeat (12) @(negedge SYS_CLK);
      SYS_RST = 1'b0;
      chk1("native", 1'b0, NATIVE_MODE);
      rdc(STAT_OFF, 16'hFC07, 16'h0001, "status");
      rdc(CTRL_OFF, 16'hFE00, 16'h0000, "flags");
      $display("reset test done");
      for (int i = 0; i < 6; i++) begin
         wr(CTRL_OFF, 16'h0001 | (16'h0004 << i));
         rdc(STAT_OFF, 16'hFC07, 16'h0001 | (16'h0400 << i), "mask");
         pulse(6'h01 << ((i + 1) % 6));
         chk1("masked", 1'b1, HOST_IRQ_N);
         pulse(6'h01 << i);
         chk1("irq", 1'b0, HOST_IRQ_N);
         rdc(CTRL_OFF, 16'hFE00, (16'h0001 << fb[i]) | (16'h0001 << fb[(i + 1) % 6]), "flag");
         chk1("irq clear", 1'b1, HOST_IRQ_N);
      end
      pulse(6'h01);
      pulse(6'h01);
      rdc(CTRL_OFF, 16'hFE00, 16'h2800, "overflow");
      rdc(CTRL_OFF, 16'hFE00, 16'h0000, "cleared");
      IRQ_EVENTS = 6'h02;
      rdc(CTRL_OFF, 16'hFE00, 16'h4000, "held");
      IRQ_EVENTS = 6'h00;
      rdc(CTRL_OFF, 16'hFE00, 16'h4000, "kept");
      $display("interrupt test done");
      wr(CTRL_OFF, 16'h0003);
      wr(CTRL_OFF, 16'h0001);
      chk("steps", 16'h0001, 16'(steps));
      {PROFILE_TOGGLE, FROZEN_INDICATOR, HALT_PIN_N} = 3'h6;
      wr(CTRL_OFF, 16'hA000);
      chk1("run", 1'b0, PROC_HALT);
      chk1("native", 1'b1, NATIVE_MODE);
      chk1("monitor", 1'b0, MONITOR_PIN_N);
      rdc(STAT_OFF, 16'hFC07, 16'h0007, "status");
      HALT_PIN_N = 1'b1;
      wr(CTRL_OFF, 16'h0002);
      chk("steps", 16'h0001, 16'(steps));
      $display("control test done");
      foreach (ao[k]) begin
         wr(ao[k], 16'h1230 + 16'(k));
         chk("area off", {7'h00, ao[k]}, {7'h00, last_off});
         chk("area data", 16'h1230 + 16'(k), last_wd);
         chk1("area write", 1'b1, last_we);
         chk1("resumed", 1'b0, PROC_HALT);
         rdc(ao[k], 16'hFFFF, {7'h00, ao[k]} ^ 16'hA5C3, "area read");
      end
      chk("strobes", 16'h0006, 16'(strobes));
      wr(CTRL_OFF, 16'h0001);
      wr(ao[0], 16'h0055);
      chk1("stays halted", 1'b1, PROC_HALT);
      host(1'b0, 1'b1, 1'b0, CTRL_OFF, 16'h0000, 4'h0);
      chk1("bad be write", 1'b1, PROC_HALT);
      host(1'b0, 1'b1, 1'b1, STAT_OFF, 16'h0000, 4'hF);
      chk("bad be read", 16'h0000, rd);
      $display("area test done");
      foreach (dl[k]) begin
         delay = dl[k];
         host(1'b1, 1'b0, 1'(k), 9'h010, 16'hBEEF, 4'h0);
         chk1("vram ready", 1'b1, r);
      end
      chk("memory_request_n cycles", 16'h0002, 16'(mreqs));
      host(1'b1, 1'b1, 1'b0, 9'h020, 16'h0F0F, 4'h0);
      chk1("ext no ready", 1'b0, r);
      ext_ready = 1'b1;
      host(1'b1, 1'b1, 1'b1, 9'h020, 16'h0F0F, 4'h0);
      ext_ready = 1'b0;
      chk1("ext ready", 1'b1, r);
      $display("cycle test done");
      close_out();
   end
endmodule
`default_nettype wire
